// ===== inc/adccc_pkg.sv
package adccc_pkg;
	// conversion timing on the internal conversion clock
	localparam int CONV_TIME_NS = 1000;
	localparam int CLK_PERIOD_NS = 8;
	localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NUM_CHANNELS = 4;
	localparam int SAMPLE_WIDTH = 16;
	// io mode encodings
	localparam logic MODE_SINGLE_ENDED = 1'b0;
	localparam logic MODE_DIFFERENTIAL = 1'b1;
	// conversion sequencer states
	typedef enum logic [1:0] {
		ADCCC_IDLE,
		ADCCC_CONVERT,
		ADCCC_POWERED_DOWN
	} adccc_state_e;
endpackage : adccc_pkg

// ===== hdl/adccc_edge_detect.sv
`timescale 1ns/1ps
// rising edge detector for synchronous inputs
module adccc_edge_detect (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic level_in,
	output logic rise_out
);
	logic prev;
	logic next_prev;

	// remember last level; reset low so a high level at release counts as edge
	always_comb begin
		next_prev = level_in;
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			prev <= 1'b0;
		end else begin
			prev <= next_prev;
		end
	end

	assign rise_out = level_in & ~prev;
endmodule : adccc_edge_detect

// ===== hdl/adccc_conversion_control.sv
`timescale 1ns/1ps
module adccc_conversion_control
	import adccc_pkg::*;
#(
	parameter int CONV_CYCLES_P = CONV_CYCLES,
	parameter int CHANNELS_P = NUM_CHANNELS,
	parameter int WIDTH_P = SAMPLE_WIDTH
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic convert_strobe_in,
	input wire logic power_down_in,
	input wire logic chip_select_n_in,
	input wire logic mode_strap_in,
	input wire logic [CHANNELS_P*WIDTH_P-1:0] channel_data_in,
	output logic busy_out,
	output logic hold_out,
	output logic powered_down_out,
	output logic global_reset_out,
	output logic differential_mode_out,
	output logic [CHANNELS_P*WIDTH_P-1:0] sample_out,
	output logic conversion_done_out
);
	localparam int CW = $clog2(CONV_CYCLES_P + 1);

	initial begin
		if (CONV_CYCLES_P < 1 || CHANNELS_P < 1 || WIDTH_P < 1) begin
			$error("adccc_conversion_control: bad parameter");
		end
	end

	////////////////////////////////////////////////////////////////////////
	// edge detection

	logic cnv_rise;
	logic pd_rise;

	// chip select deliberately not used for the strobe
	adccc_edge_detect u_cnv_edge (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.level_in(convert_strobe_in),
		.rise_out(cnv_rise)
	);

	// only srst clears the history: power-down is still high after a global reset,
	// and clearing it then would fake a rise and re-arm the pairing
	adccc_edge_detect u_pd_edge (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.level_in(power_down_in),
		.rise_out(pd_rise)
	);

	////////////////////////////////////////////////////////////////////////
	// sequencer

	adccc_state_e state;
	adccc_state_e next_state;
	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic pd_armed;
	logic next_pd_armed;
	logic greset;
	logic next_greset;
	logic done;
	logic next_done;
	logic [CHANNELS_P*WIDTH_P-1:0] sample;
	logic [CHANNELS_P*WIDTH_P-1:0] next_sample;
	logic mode;
	logic next_mode;
	logic mode_valid;
	logic next_mode_valid;

	always_comb begin
		next_state = state;
		next_count = count;
		next_pd_armed = pd_armed;
		next_greset = 1'b0;
		next_done = 1'b0;
		next_sample = sample;
		next_mode = mode;
		next_mode_valid = 1'b1;
		// strap caught once after reset release
		if (!mode_valid) begin
			next_mode = mode_strap_in;
		end
		// second pulse without a conversion between: global reset
		if (pd_rise) begin
			if (pd_armed) begin
				next_greset = 1'b1;
				next_pd_armed = 1'b0;
			end else begin
				next_pd_armed = 1'b1;
			end
		end
		case (state)
			ADCCC_IDLE: begin
				if (power_down_in) begin
					next_state = ADCCC_POWERED_DOWN;
				end else if (cnv_rise) begin
					// all channels frozen together
					next_state = ADCCC_CONVERT;
					next_count = CW'(CONV_CYCLES_P);
					next_sample = channel_data_in;
					next_pd_armed = 1'b0;
				end
			end
			ADCCC_CONVERT: begin
				// strobe edges dropped while converting
				if (count == CW'(1)) begin
					next_done = 1'b1;
					next_state = power_down_in ? ADCCC_POWERED_DOWN : ADCCC_IDLE;
				end
				next_count = count - CW'(1);
			end
			ADCCC_POWERED_DOWN: begin
				if (!power_down_in) begin
					next_state = ADCCC_IDLE; // strobes ignored until here
				end
			end
			default: next_state = ADCCC_IDLE;
		endcase
	end

	// global reset pulse acts like srst on all control state except the edge detector histories
	always_ff @(posedge clk_in) begin
		if (srst_in || greset) begin
			state <= ADCCC_IDLE;
			count <= '0;
			pd_armed <= 1'b0;
			done <= 1'b0;
			sample <= '0;
			mode_valid <= 1'b0;
			mode <= MODE_SINGLE_ENDED;
		end else begin
			state <= next_state;
			count <= next_count;
			pd_armed <= next_pd_armed;
			done <= next_done;
			sample <= next_sample;
			mode_valid <= next_mode_valid;
			mode <= next_mode;
		end
		greset <= srst_in ? 1'b0 : next_greset;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign busy_out = (state == ADCCC_CONVERT);
	assign hold_out = (state == ADCCC_CONVERT);
	assign powered_down_out = (state == ADCCC_POWERED_DOWN);
	assign global_reset_out = greset;
	assign differential_mode_out = (mode == MODE_DIFFERENTIAL);
	assign sample_out = sample;
	assign conversion_done_out = done;

	////////////////////////////////////////////////////////////////////////
	// checks

	// busy length counter for the checks; a repetition cannot follow the parameter
	logic [CW-1:0] busy_run;
	logic [CW-1:0] next_busy_run;

	always_comb begin
		next_busy_run = '0;
		if (busy_out) begin
			next_busy_run = busy_run + CW'(1);
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in || greset) begin
			busy_run <= '0;
		end else begin
			busy_run <= next_busy_run;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in || greset);

	chk_start_busy: assert property (cnv_rise && state == ADCCC_IDLE && !power_down_in |=> busy_out)
		else $error("strobe did not start conversion");
	chk_busy_len: assert property ($fell(busy_out) |-> busy_run == CW'(CONV_CYCLES_P))
		else $error("busy length differs from conversion time");
	chk_done_pulse: assert property (busy_out && count == CW'(1) |=> conversion_done_out && !busy_out)
		else $error("conversion end not flagged");
	chk_pd_ignore: assert property (powered_down_out && power_down_in |=> !busy_out)
		else $error("conversion started while powered down");
	chk_pd_finish: assert property (busy_out && power_down_in && count > CW'(1) |=> busy_out)
		else $error("power-down cut conversion");
	chk_pd_after: assert property (busy_out && count == CW'(1) && power_down_in |=> powered_down_out)
		else $error("no power-down after conversion");
	chk_double_pd: assert property (disable iff (srst_in) pd_rise && pd_armed |=> global_reset_out)
		else $error("double power-down did not reset");
	chk_busy_ignore: assert property (busy_out && cnv_rise && count > CW'(1) |=> busy_out && $stable(sample))
		else $error("strobe disturbed conversion");
	chk_sample_all: assert property ($rose(busy_out) |-> sample == $past(channel_data_in))
		else $error("channels not sampled together");
	chk_mode_stable: assert property (mode_valid |=> $stable(differential_mode_out))
		else $error("mode changed after reset");

	cov_conversion: cover property ($rose(busy_out) ##[1:300] conversion_done_out);
	cov_pd_mid: cover property (busy_out && $rose(power_down_in));
	cov_greset: cover property (global_reset_out);
	cov_cs_high_start: cover property (chip_select_n_in && $rose(busy_out));
endmodule : adccc_conversion_control

// ===== tb/adccc_host_model.sv
`timescale 1ns/1ps
// host side: sequences conversions and power-down on the falling edge
module adccc_host_model (
	input wire logic clk_in,
	output logic convert_strobe_out,
	output logic power_down_out
);
	initial begin
		convert_strobe_out = 1'b0;
		power_down_out = 1'b0;
	end
	// one full cycle high so the strobe never looks like a glitch
	task automatic strobe();
		@(negedge clk_in) convert_strobe_out = 1'b1;
		@(negedge clk_in) convert_strobe_out = 1'b0;
	endtask : strobe
	// repeated rises with no conversion between reset the device
	task automatic set_pd(input logic level);
		@(negedge clk_in) power_down_out = level;
	endtask : set_pd
endmodule : adccc_host_model

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench
	import adccc_pkg::*;
;
	localparam int CONV = 4;
	localparam int W = NUM_CHANNELS * SAMPLE_WIDTH;
	logic clk_in, srst_in, cs_n, strap;
	logic [W-1:0] data;
	logic strobe, pd, busy, hold, pd_state, greset, diff, done;
	logic [W-1:0] sample;
	int errors = 0, samples_checked = 0, n, resets = 0;
	logic [W-1:0] row_data [4] = '{64'h0123_4567_89ab_cdef, 64'hffff_0000_ffff_0000,
		64'h0000_0000_0000_0001, 64'h8000_7fff_a5a5_5a5a};
	logic row_cs [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
	////////////////////////////////////////////////////////////////
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	adccc_host_model i_adccc_host_model (.clk_in(clk_in), .convert_strobe_out(strobe), .power_down_out(pd));
	adccc_conversion_control #(.CONV_CYCLES_P(CONV)) i_adccc_conversion_control (.clk_in(clk_in),
		.srst_in(srst_in), .convert_strobe_in(strobe), .power_down_in(pd), .chip_select_n_in(cs_n),
		.mode_strap_in(strap), .channel_data_in(data), .busy_out(busy), .hold_out(hold),
		.powered_down_out(pd_state), .global_reset_out(greset), .differential_mode_out(diff),
		.sample_out(sample), .conversion_done_out(done));
	// reset pulse lasts one cycle, so count it as it passes
	always @(posedge clk_in) if (greset === 1'b1) resets++;
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic do_reset(input logic s);
		@(negedge clk_in);
		srst_in = 1'b1;
		strap = s;
		repeat (20) @(negedge clk_in);
		srst_in = 1'b0;
		repeat (3) @(negedge clk_in);
	endtask : do_reset
	// inputs are scrambled after the strobe to prove capture at start
	task automatic convert(input logic [W-1:0] d);
		data = d;
		n = 0;
		i_adccc_host_model.strobe();
		data = ~d;
		// strobe returns one edge after acceptance, so the first busy cycle counts here
		n = (busy === 1'b1 && hold === 1'b1) ? 1 : 0;
		repeat (CONV + 4) begin
			@(posedge clk_in);
			#1;
			if (busy === 1'b1 && hold === 1'b1) n++;
			else break;
		end
	endtask : convert
	task automatic final_report();
		$display("compared %0d, mismatched %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////////
	initial begin
		#(8 * 3000);
		errors++;
		final_report();
	end
	// table rows first, then the awkward cases
	initial begin
		srst_in = 1'b1;
		cs_n = 1'b1;
		strap = 1'b1;
		data = '0;
		do_reset(1'b1);
		check(W'(diff), W'(1'b1));
		for (int i = 0; i < 4; i++) begin
			@(negedge clk_in);
			cs_n = row_cs[i];
			convert(row_data[i]);
			check(W'(n), W'(CONV));
			check(W'(done), W'(1'b1));
			check(sample, row_data[i]);
			$display("row %0d finished", i);
		end
		fork
			convert(row_data[0]);
			begin
				// second rise lands while the countdown is still above one
				repeat (2) @(negedge clk_in);
				i_adccc_host_model.strobe();
			end
		join
		check(W'(n), W'(CONV));
		$display("strobe during busy finished");
		i_adccc_host_model.set_pd(1'b1);
		convert(row_data[1]);
		check(W'(n), W'(0));
		check(W'(pd_state), W'(1'b1));
		check(sample, row_data[0]);
		i_adccc_host_model.set_pd(1'b0);
		repeat (2) @(negedge clk_in);
		check(W'(pd_state), W'(1'b0));
		$display("idle power-down finished");
		fork
			convert(row_data[2]);
			begin
				// power-down rises with two conversion cycles left
				repeat (2) @(negedge clk_in);
				i_adccc_host_model.set_pd(1'b1);
			end
		join
		check(W'(n), W'(CONV));
		check(W'(pd_state), W'(1'b1));
		check(W'(resets), W'(0));
		i_adccc_host_model.set_pd(1'b0);
		i_adccc_host_model.set_pd(1'b1);
		repeat (3) @(negedge clk_in);
		check(W'(resets), W'(1));
		check(sample, '0);
		i_adccc_host_model.set_pd(1'b0);
		$display("power-down sequences finished");
		do_reset(1'b0);
		check(W'(diff), W'(1'b0));
		$display("strap low finished");
		final_report();
	end
endmodule : testbench
